/* logic/lcd_cfg.svh */
// Offsets, field positions and reset values of the loop closure detector
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// -----------------------------------------------------------------------------
// Direct register offsets
// -----------------------------------------------------------------------------
`define LCD_DIR_IRQ_PENDING 8'h13
`define LCD_DIR_IRQ_ENABLE 8'h16
`define LCD_DIR_HOOK_STATUS 8'h44
`define LCD_DIR_DEBOUNCE 8'h45
`define LCD_DIR_ENH_CTRL 8'h6c

// -----------------------------------------------------------------------------
// Indirect register offsets
// -----------------------------------------------------------------------------
`define LCD_IND_THR_HI 8'h1c
`define LCD_IND_COEFF 8'h23
`define LCD_IND_THR_LO 8'h2b

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define LCD_IRQ_BIT 1
`define LCD_STATUS_BIT 1
`define LCD_HYST_BIT 0
`define LCD_VMODE_BIT 2
`define LCD_FILT_FRAC 13

// -----------------------------------------------------------------------------
// Linefeed shadow codes in which detection runs
// -----------------------------------------------------------------------------
`define LCD_LF_FWD_ACTIVE 3'h1
`define LCD_LF_FWD_OHT 3'h2
`define LCD_LF_REV_ACTIVE 3'h5
`define LCD_LF_REV_OHT 3'h6

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define LCD_RST_THR_HI 6'h10
`define LCD_RST_THR_LO 6'h0c
`define LCD_RST_COEFF 13'h0200
`define LCD_RST_DEBOUNCE 7'h0c
`define LCD_RST_ENH 8'h00
`define LCD_RST_IRQ_EN 8'h00

`endif

/* logic/lcd_pkg.sv */
// Types shared by the loop closure detector
package lcd_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lcd_dir_req_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} lcd_ind_req_type;

	// Sign-magnitude samples from the monitor converter
	typedef struct packed {
		logic valid;
		logic [6:0] current;
		logic [7:0] voltage;
	} lcd_sample_type;

	typedef enum logic {
		CMP_OPEN,
		CMP_CLOSED
	} lcd_cmp_state_type;

endpackage

/* logic/lcd_top.sv */
// Loop closure (off-hook) detector: filter, threshold, debounce, status
//
// Operation
// - Process samples only in forward and reverse active and OHT linefeed states
// - Low-pass filter samples, 13-bit coefficient
// - Compare filter output to 6-bit threshold
// - Debounce: flip only after full opposite interval
// - Set detect status once debounce satisfied
// - Pending bit and interrupt only when enabled
// - Hysteresis: upper main, lower separate threshold
// - Voltage mode compares minimum loop voltage
// - Voltage with hysteresis uses both bounds
`include "lcd_cfg.svh"

module lcd_top (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [2:0] LINEFEED_SHADOW_STATE,
	input wire lcd_pkg::lcd_sample_type SAMPLE,
	input wire lcd_pkg::lcd_dir_req_type DIR_REQ,
	output logic [7:0] DIR_RDATA,
	input wire lcd_pkg::lcd_ind_req_type IND_REQ,
	output logic [15:0] IND_RDATA,
	output logic OFFHOOK_DETECTED,
	output logic IRQ_N
);

	// -------------------------------------------------------------------------
	// Register state
	// -------------------------------------------------------------------------
	logic [5:0] thr_hi_q, thr_hi_d;
	logic [5:0] thr_lo_q, thr_lo_d;
	logic [12:0] coeff_q, coeff_d;
	logic [6:0] debounce_len_q, debounce_len_d;
	logic [7:0] enh_q, enh_d;
	logic [7:0] irq_en_q, irq_en_d;
	logic pend_q, pend_d;
	logic [7:0] dir_rdata_q, dir_rdata_d;
	logic [15:0] ind_rdata_q, ind_rdata_d;

	// -------------------------------------------------------------------------
	// Datapath state
	// -------------------------------------------------------------------------
	logic [19:0] acc_q, acc_d;
	lcd_pkg::lcd_cmp_state_type cmp_q, cmp_d;
	logic [6:0] cnt_q, cnt_d;
	logic det_q, det_d;

	logic hysteresis_enable;
	logic voltage_mode_enable;
	logic offhook_irq_enable;
	logic in_detect_state;
	logic take_sample;
	logic offhook_event;
	logic [6:0] sample_mag;
	logic [6:0] filt;
	logic [5:0] cmp_val;
	logic signed [20:0] diff;
	logic signed [34:0] prod;
	logic signed [20:0] step;
	logic signed [20:0] acc_sum;

	assign hysteresis_enable = enh_q[`LCD_HYST_BIT];
	assign voltage_mode_enable = enh_q[`LCD_VMODE_BIT];
	assign offhook_irq_enable = irq_en_q[`LCD_IRQ_BIT];

	// -------------------------------------------------------------------------
	// Sample gating
	// -------------------------------------------------------------------------
	always_comb begin
		case (LINEFEED_SHADOW_STATE)
			`LCD_LF_FWD_ACTIVE,
			`LCD_LF_FWD_OHT,
			`LCD_LF_REV_ACTIVE,
			`LCD_LF_REV_OHT: in_detect_state = 1'b1;
			default: in_detect_state = 1'b0;
		endcase
	end

	// Outside detect states all filter and debounce state is frozen
	assign take_sample = SAMPLE.valid && in_detect_state;

	// Sign bit dropped: both line polarities count alike
	assign sample_mag = voltage_mode_enable ? SAMPLE.voltage[6:0] :
		{1'b0, SAMPLE.current[5:0]};

	// -------------------------------------------------------------------------
	// Low-pass filter: acc += (x - acc) * coeff / 2^13
	// -------------------------------------------------------------------------
	always_comb begin
		diff = $signed({1'b0, sample_mag, 13'h0000}) - $signed({1'b0, acc_q});
		prod = diff * $signed({1'b0, coeff_q});
		step = prod[33:`LCD_FILT_FRAC];
		acc_sum = $signed({1'b0, acc_q}) + step;
		acc_d = acc_q;
		if (take_sample) begin
			acc_d = acc_sum[19:0];
		end
	end

	assign filt = acc_q[19:`LCD_FILT_FRAC];
	// Voltage steps are half the current steps, so drop one bit
	assign cmp_val = voltage_mode_enable ? filt[6:1] : filt[5:0];

	// -------------------------------------------------------------------------
	// Threshold comparator
	// -------------------------------------------------------------------------
	always_comb begin
		cmp_d = cmp_q;
		if (!hysteresis_enable) begin
			if (voltage_mode_enable) begin
				cmp_d = (cmp_val < thr_hi_q) ? lcd_pkg::CMP_CLOSED :
					lcd_pkg::CMP_OPEN;
			end else begin
				cmp_d = (cmp_val > thr_hi_q) ? lcd_pkg::CMP_CLOSED :
					lcd_pkg::CMP_OPEN;
			end
		end else begin
			case (cmp_q)
				lcd_pkg::CMP_OPEN: begin
					if (voltage_mode_enable && cmp_val < thr_lo_q) begin
						cmp_d = lcd_pkg::CMP_CLOSED;
					end else if (!voltage_mode_enable && cmp_val > thr_hi_q) begin
						cmp_d = lcd_pkg::CMP_CLOSED;
					end
				end
				lcd_pkg::CMP_CLOSED: begin
					if (voltage_mode_enable && cmp_val > thr_hi_q) begin
						cmp_d = lcd_pkg::CMP_OPEN;
					end else if (!voltage_mode_enable && cmp_val < thr_lo_q) begin
						cmp_d = lcd_pkg::CMP_OPEN;
					end
				end
				default: cmp_d = lcd_pkg::CMP_OPEN;
			endcase
		end
		if (!take_sample) begin
			cmp_d = cmp_q;
		end
	end

	// -------------------------------------------------------------------------
	// Debounce: counts samples that disagree with the settled output
	// -------------------------------------------------------------------------
	always_comb begin
		cnt_d = cnt_q;
		det_d = det_q;
		if (take_sample) begin
			if ((cmp_q == lcd_pkg::CMP_CLOSED) != det_q) begin
				if (cnt_q >= debounce_len_q) begin
					det_d = ~det_q;
					cnt_d = 7'h00;
				end else begin
					cnt_d = cnt_q + 7'h01;
				end
			end else begin
				// Any agreeing sample restarts the interval
				cnt_d = 7'h00;
			end
		end
	end

	assign offhook_event = det_d && !det_q;

	// -------------------------------------------------------------------------
	// Register writes and interrupt pending
	// -------------------------------------------------------------------------
	always_comb begin
		irq_en_d = irq_en_q;
		debounce_len_d = debounce_len_q;
		enh_d = enh_q;
		pend_d = pend_q;
		if (DIR_REQ.wr) begin
			case (DIR_REQ.addr)
				`LCD_DIR_IRQ_ENABLE: irq_en_d = DIR_REQ.wdata;
				`LCD_DIR_DEBOUNCE: debounce_len_d = DIR_REQ.wdata[6:0];
				`LCD_DIR_ENH_CTRL: enh_d = DIR_REQ.wdata;
				`LCD_DIR_IRQ_PENDING: begin
					if (DIR_REQ.wdata[`LCD_IRQ_BIT]) begin
						pend_d = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// A new event beats a clear in the same cycle
		if (offhook_event && offhook_irq_enable) begin
			pend_d = 1'b1;
		end
	end

	always_comb begin
		thr_hi_d = thr_hi_q;
		thr_lo_d = thr_lo_q;
		coeff_d = coeff_q;
		if (IND_REQ.wr) begin
			case (IND_REQ.addr)
				`LCD_IND_THR_HI: thr_hi_d = IND_REQ.wdata[5:0];
				`LCD_IND_THR_LO: thr_lo_d = IND_REQ.wdata[5:0];
				`LCD_IND_COEFF: coeff_d = IND_REQ.wdata[12:0];
				default: ;
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// Read paths, one cycle after the read strobe
	// -------------------------------------------------------------------------
	always_comb begin
		dir_rdata_d = dir_rdata_q;
		if (DIR_REQ.rd) begin
			dir_rdata_d = 8'h00;
			case (DIR_REQ.addr)
				`LCD_DIR_IRQ_PENDING: dir_rdata_d[`LCD_IRQ_BIT] = pend_q;
				`LCD_DIR_IRQ_ENABLE: dir_rdata_d = irq_en_q;
				`LCD_DIR_HOOK_STATUS: dir_rdata_d[`LCD_STATUS_BIT] = det_q;
				`LCD_DIR_DEBOUNCE: dir_rdata_d = {1'b0, debounce_len_q};
				`LCD_DIR_ENH_CTRL: dir_rdata_d = enh_q;
				default: dir_rdata_d = 8'h00;
			endcase
		end
	end

	always_comb begin
		ind_rdata_d = ind_rdata_q;
		if (IND_REQ.rd) begin
			case (IND_REQ.addr)
				`LCD_IND_THR_HI: ind_rdata_d = {10'h000, thr_hi_q};
				`LCD_IND_THR_LO: ind_rdata_d = {10'h000, thr_lo_q};
				`LCD_IND_COEFF: ind_rdata_d = {3'h0, coeff_q};
				default: ind_rdata_d = 16'h0000;
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// Flip-flops
	// -------------------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_en_q <= `LCD_RST_IRQ_EN;
			debounce_len_q <= `LCD_RST_DEBOUNCE;
			enh_q <= `LCD_RST_ENH;
			pend_q <= 1'b0;
		end else begin
			irq_en_q <= irq_en_d;
			debounce_len_q <= debounce_len_d;
			enh_q <= enh_d;
			pend_q <= pend_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			thr_hi_q <= `LCD_RST_THR_HI;
			thr_lo_q <= `LCD_RST_THR_LO;
			coeff_q <= `LCD_RST_COEFF;
		end else begin
			thr_hi_q <= thr_hi_d;
			thr_lo_q <= thr_lo_d;
			coeff_q <= coeff_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dir_rdata_q <= 8'h00;
		end else begin
			dir_rdata_q <= dir_rdata_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ind_rdata_q <= 16'h0000;
		end else begin
			ind_rdata_q <= ind_rdata_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			acc_q <= 20'h00000;
		end else begin
			acc_q <= acc_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmp_q <= lcd_pkg::CMP_OPEN;
		end else begin
			cmp_q <= cmp_d;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_q <= 7'h00;
			det_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			det_q <= det_d;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	assign DIR_RDATA = dir_rdata_q;
	assign IND_RDATA = ind_rdata_q;
	assign OFFHOOK_DETECTED = det_q;
	// Masking again here lets software silence a pending bit by disabling it
	assign IRQ_N = ~(pend_q && offhook_irq_enable);

endmodule // lcd_top

/* dv/lcd_assertions.sv */
// Port-level checks for the loop closure detector
`include "lcd_cfg.svh"
module lcd_assertions (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [2:0] LINEFEED_SHADOW_STATE,
	input wire lcd_pkg::lcd_sample_type SAMPLE,
	input wire lcd_pkg::lcd_dir_req_type DIR_REQ,
	input wire logic [7:0] DIR_RDATA,
	input wire lcd_pkg::lcd_ind_req_type IND_REQ,
	input wire logic [15:0] IND_RDATA,
	input wire logic OFFHOOK_DETECTED,
	input wire logic IRQ_N
);
	timeunit 1ns;
	timeprecision 1ps;
	logic taken;
	assign taken = SAMPLE.valid && LINEFEED_SHADOW_STATE inside {3'h1, 3'h2, 3'h5, 3'h6};
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	det_hold_a: assert property (!taken |=> $stable(OFFHOOK_DETECTED))
		else $error("detect moved without a sample");
	irq_set_a: assert property ($fell(IRQ_N) |-> $rose(OFFHOOK_DETECTED) ||
		$past(DIR_REQ.wr && DIR_REQ.addr == `LCD_DIR_IRQ_ENABLE))
		else $error("interrupt without cause");
	irq_clear_a: assert property (DIR_REQ.wr && DIR_REQ.addr == `LCD_DIR_IRQ_PENDING &&
		DIR_REQ.wdata[`LCD_IRQ_BIT] |=> IRQ_N || $rose(OFFHOOK_DETECTED))
		else $error("interrupt not cleared");
	status_read_a: assert property (DIR_REQ.rd && DIR_REQ.addr == `LCD_DIR_HOOK_STATUS
		|=> DIR_RDATA == {6'h00, $past(OFFHOOK_DETECTED), 1'b0})
		else $error("status read wrong");
	pend_read_a: assert property (DIR_REQ.rd && DIR_REQ.addr == `LCD_DIR_IRQ_PENDING &&
		!IRQ_N |=> DIR_RDATA[`LCD_IRQ_BIT])
		else $error("pending bit not read back");
	dir_hold_a: assert property (!DIR_REQ.rd |=> $stable(DIR_RDATA))
		else $error("direct read data moved");
	ind_hold_a: assert property (!IND_REQ.rd |=> $stable(IND_RDATA))
		else $error("indirect read data moved");
	unmap_rd_a: assert property (DIR_REQ.rd && DIR_REQ.addr == 8'h00 |=> DIR_RDATA == 8'h00)
		else $error("unmapped read not zero");
endmodule // lcd_assertions

/* dv/lcd_sampler.sv */
// Monitor converter model: one sample per request
module lcd_sampler (
	input wire logic clk,
	input wire logic send,
	input wire logic [6:0] cur,
	input wire logic [7:0] volt,
	output lcd_pkg::lcd_sample_type sample
);
	timeunit 1ns;
	timeprecision 1ps;
	logic go_q = 1'b0;
	initial sample = '0;
	always @(posedge clk) go_q <= send;
	// Data inverts between strobes so a stale value never passes as fresh
	always @(negedge clk) begin
		sample.valid <= go_q;
		sample.current <= go_q ? cur : ~sample.current;
		sample.voltage <= go_q ? volt : ~sample.voltage;
	end
endmodule // lcd_sampler

/* dv/lcd_top_tb.sv */
// Self-checking bench for the loop closure detector
module lcd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic send = 1'b0;
	logic [2:0] lf = 3'h0;
	logic [6:0] cur = 7'h00;
	logic [7:0] volt = 8'h00;
	lcd_pkg::lcd_sample_type smp;
	lcd_pkg::lcd_dir_req_type dreq = '0;
	lcd_pkg::lcd_ind_req_type ireq = '0;
	logic [7:0] drdata;
	logic [15:0] irdata;
	logic det;
	logic irq_n;
	int bad_count = 0;
	int compares = 0;
	always #2 clk = ~clk;
	lcd_sampler lcd_sampler_inst (.clk(clk), .send(send), .cur(cur), .volt(volt), .sample(smp));
	lcd_top lcd_top_inst (.SYS_CLK(clk), .RST_N(rst_n), .LINEFEED_SHADOW_STATE(lf),
		.SAMPLE(smp), .DIR_REQ(dreq), .DIR_RDATA(drdata), .IND_REQ(ireq),
		.IND_RDATA(irdata), .OFFHOOK_DETECTED(det), .IRQ_N(irq_n));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic dwr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		dreq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge clk);
		dreq.wr <= 1'b0;
	endtask
	task automatic dchk(input string n, input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		dreq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		dreq.rd <= 1'b0;
		chk(n, {8'h00, e}, {8'h00, drdata});
	endtask
	task automatic iwr(input logic [7:0] a, input logic [15:0] v);
		@(negedge clk);
		ireq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge clk);
		ireq.wr <= 1'b0;
	endtask
	task automatic ichk(input string n, input logic [7:0] a, input logic [15:0] e);
		@(negedge clk);
		ireq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge clk);
		ireq.rd <= 1'b0;
		chk(n, e, irdata);
	endtask
	// Sends n samples, then judges the settled detect level
	task automatic step(input logic [6:0] c, input logic [7:0] v, input int n, input logic e);
		cur <= c;
		volt <= v;
		repeat (n) begin
			@(negedge clk);
			send <= 1'b1;
			@(negedge clk);
			send <= 1'b0;
		end
		repeat (4) @(negedge clk);
		chk("detect", {15'h0000, e}, {15'h0000, det});
	endtask
	task automatic t_regs();
		dchk("status", 8'h44, 8'h00);
		dwr(8'h44, 8'hff);
		dchk("status_ro", 8'h44, 8'h00);
		dchk("debounce", 8'h45, 8'h0c);
		dchk("enh", 8'h6c, 8'h00);
		dchk("irq_en", 8'h16, 8'h00);
		dchk("unmapped", 8'h00, 8'h00);
		ichk("thr_hi", 8'h1c, 16'h0010);
		ichk("thr_lo", 8'h2b, 16'h000c);
		ichk("coeff", 8'h23, 16'h0200);
		ichk("ind_unmapped", 8'h00, 16'h0000);
	endtask
	task automatic t_gate();
		iwr(8'h23, 16'h1fff);
		ichk("coeff_rw", 8'h23, 16'h1fff);
		dwr(8'h45, 8'h02);
		lf <= 3'h0;
		step(7'h30, 8'h00, 6, 1'b0);
		lf <= 3'h3;
		step(7'h30, 8'h00, 6, 1'b0);
		lf <= 3'h4;
		step(7'h30, 8'h00, 6, 1'b0);
		lf <= 3'h7;
		step(7'h30, 8'h00, 6, 1'b0);
		lf <= 3'h2;
		step(7'h30, 8'h00, 4, 1'b0);
		step(7'h30, 8'h00, 1, 1'b1);
		dchk("status_set", 8'h44, 8'h02);
		dchk("pending_masked", 8'h13, 8'h00);
		chk("irq_masked", 16'h0001, {15'h0000, irq_n});
	endtask
	task automatic t_irq();
		lf <= 3'h1;
		dwr(8'h16, 8'h02);
		step(7'h02, 8'h00, 6, 1'b0);
		chk("irq_idle", 16'h0001, {15'h0000, irq_n});
		step(7'h30, 8'h00, 6, 1'b1);
		chk("irq_low", 16'h0000, {15'h0000, irq_n});
		dchk("pending", 8'h13, 8'h02);
		dwr(8'h13, 8'h02);
		chk("irq_cleared", 16'h0001, {15'h0000, irq_n});
		dchk("pending_clr", 8'h13, 8'h00);
	endtask
	task automatic t_hyst();
		lf <= 3'h5;
		dwr(8'h6c, 8'h01);
		iwr(8'h1c, 16'h0020);
		iwr(8'h2b, 16'h0008);
		step(7'h11, 8'h00, 6, 1'b1);
		step(7'h03, 8'h00, 6, 1'b0);
		step(7'h11, 8'h00, 6, 1'b0);
		step(7'h30, 8'h00, 6, 1'b1);
	endtask
	task automatic t_volt();
		lf <= 3'h6;
		dwr(8'h6c, 8'h04);
		iwr(8'h1c, 16'h0010);
		step(7'h00, 8'h7f, 6, 1'b0);
		step(7'h00, 8'h10, 6, 1'b1);
		dwr(8'h6c, 8'h05);
		iwr(8'h1c, 16'h0020);
		step(7'h00, 8'h21, 6, 1'b1);
		step(7'h00, 8'h7f, 6, 1'b0);
		step(7'h00, 8'h21, 6, 1'b0);
		step(7'h00, 8'h08, 6, 1'b1);
		// Host goes back to the default current-based mode
		dwr(8'h6c, 8'h00);
		dchk("enh_default", 8'h6c, 8'h00);
	endtask
	task automatic report_and_stop();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Whole run is a few hundred cycles; this leaves wide margin
	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_gate();
		t_irq();
		t_hyst();
		t_volt();
		report_and_stop();
	end
endmodule // lcd_top_tb
bind lcd_top lcd_assertions lcd_assertions_inst (.SYS_CLK, .RST_N, .LINEFEED_SHADOW_STATE,
	.SAMPLE, .DIR_REQ, .DIR_RDATA, .IND_REQ, .IND_RDATA, .OFFHOOK_DETECTED, .IRQ_N);
